// ==== rtl/slave_address_composer.sv ====
// Purpose: composes and holds the serial slave address, filters frames
// Assumes: rst_n is the power-on reset; inputs synchronous to clk
// Notes:   the address is only captured after reset release
`timescale 1ns/1ps
`default_nettype none
`include "slave_address_composer_defines.svh"
module slave_address_composer
#(
   parameter int HW_WIDTH   = `SAC_HW_WIDTH,
   parameter int ADDR_WIDTH = `SAC_ADDR_WIDTH
)
(
   input  wire logic                                 clk,
   input  wire logic                                 rst_n,
   input  wire logic [4:0]                           dipSwitch,
   input  wire slave_address_composer_pkg::addr_t    storedOffset,
   input  wire slave_address_composer_pkg::frame_addr_s frameAddr,
   output logic                                      frameMatch,
   output slave_address_composer_pkg::addr_t         slaveAddr,
   output logic                                      addrValid,
   output logic                                      addrFault
);
   import slave_address_composer_pkg::*;

   // the port types fix both widths; other values cannot be served
   if (HW_WIDTH != $bits(hw_t))
   begin : g_check_hw_width
      $error("HW_WIDTH must equal the width of the switch bank");
   end

   if (ADDR_WIDTH != $bits(addr_t))
   begin : g_check_addr_width
      $error("ADDR_WIDTH must equal the width of the slave address");
   end

   // the widest legal sum must fit the address without a carry out
   if ((2 ** HW_WIDTH) - 1 + `SAC_OFFSET_MAX > (2 ** ADDR_WIDTH) - 1)
   begin : g_check_sum_fits
      $error("largest switch value plus offset overflows the address");
   end

   if ((2 ** HW_WIDTH) - 1 + `SAC_OFFSET_MAX > `SAC_ADDR_MAX)
   begin : g_check_sum_range
      $error("largest switch value plus offset leaves the address range");
   end

   // shipped switch and offset values must give the shipped address
   if (`SAC_HW_RESET + `SAC_OFFSET_RESET != `SAC_ADDR_MIN)
   begin : g_check_shipped
      $error("shipped switch and offset must give address one");
   end

   if (!((`SAC_OFFSET_RESET >= `SAC_OFFSET_MIN) &&
         (`SAC_OFFSET_RESET <= `SAC_OFFSET_MAX)))
   begin : g_check_fallback
      $error("fallback offset must itself be a legal offset");
   end

   comp_state_e state_reg;
   comp_state_e state_next;
   addr_t       addr_reg;
   addr_t       addr_next;
   logic        match_reg;
   logic        match_next;
   hw_t         hwAddr;
   logic        offsetLegal;
   addr_t       composedAddr;

   // switch index 4 is switch five: top bit of the value
   function automatic hw_t hw_value(input logic [4:0] sw);
      hw_value = {sw[4], sw[3], sw[2], sw[1], sw[0]};
   endfunction

   // inclusive range test, shared by the offset and the address checks
   function automatic logic in_range(input addr_t val,
                                     input addr_t lo,
                                     input addr_t hi);
      in_range = (val >= lo) && (val <= hi);
   endfunction

   function automatic logic offset_ok(input addr_t off);
      offset_ok = in_range(off, `SAC_OFFSET_MIN, `SAC_OFFSET_MAX);
   endfunction

   // widest sum 31 + 216 = 247 fits eight bits, so no carry is lost
   function automatic addr_t compose(input hw_t hw, input addr_t off);
      compose = addr_t'({3'h0, hw}) + off;
   endfunction

   // legal inputs never leave the range; kept as a guard only
   function automatic addr_t clamp_addr(input addr_t addr);
      if (in_range(addr, `SAC_ADDR_MIN, `SAC_ADDR_MAX))
      begin
         clamp_addr = addr;
      end
      else
      begin
         clamp_addr = `SAC_ADDR_MIN;
      end
   endfunction

   // both run states answer the bus; capture does not
   function automatic logic is_active(input comp_state_e st);
      is_active = (st == ST_RUN) || (st == ST_FAULT);
   endfunction

   function automatic logic addr_hit(input frame_addr_s fa, input addr_t own);
      addr_hit = fa.valid && (fa.addr == own);
   endfunction

   // inputs are decoded every cycle but used only at capture
   always_comb
   begin
      hwAddr      = hw_value(dipSwitch);
      offsetLegal = offset_ok(storedOffset);
      if (offsetLegal)
      begin
         composedAddr = compose(hwAddr, storedOffset);
      end
      else
      begin
         // a bad offset falls back to the shipped value
         composedAddr = compose(hwAddr, `SAC_OFFSET_RESET);
      end
   end

   // capture state: one capture per power-up
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_CAPTURE:
         begin
            // later switch or offset moves are ignored
            if (offsetLegal)
            begin
               state_next = ST_RUN;
            end
            else
            begin
               state_next = ST_FAULT;
            end
         end
         ST_RUN, ST_FAULT:
         begin
            // only a new power-up leaves these states
            state_next = state_reg;
         end
         default:
         begin
            state_next = ST_CAPTURE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_CAPTURE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // address: loaded once, in the capture cycle
   always_comb
   begin
      addr_next = addr_reg;
      if (state_reg == ST_CAPTURE)
      begin
         addr_next = clamp_addr(composedAddr);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_reg <= `SAC_OFFSET_RESET;
      end
      else
      begin
         addr_reg <= addr_next;
      end
   end

   // frame match: a one-cycle pulse per matching frame
   always_comb
   begin
      match_next = 1'b0;
      if (is_active(state_reg))
      begin
         match_next = addr_hit(frameAddr, addr_reg);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         match_reg <= 1'b0;
      end
      else
      begin
         match_reg <= match_next;
      end
   end

   assign slaveAddr  = addr_reg;
   assign addrValid  = is_active(state_reg);
   assign addrFault  = (state_reg == ST_FAULT);
   assign frameMatch = match_reg;
endmodule
`default_nettype wire

// ==== pkg/slave_address_composer_defines.svh ====
// Purpose: constants of the slave address composer
// Assumes: included by bare name
// Notes:   widths, ranges and shipped values
`ifndef SLAVE_ADDRESS_COMPOSER_DEFINES_SVH
`define SLAVE_ADDRESS_COMPOSER_DEFINES_SVH
`define SAC_HW_WIDTH      5
`define SAC_ADDR_WIDTH    8
`define SAC_HW_MAX        8'h1f
`define SAC_OFFSET_MIN    8'h01
`define SAC_OFFSET_MAX    8'hd8
`define SAC_ADDR_MIN      8'h01
`define SAC_ADDR_MAX      8'hf7
`define SAC_OFFSET_RESET  8'h01
`define SAC_HW_RESET      5'h00
`endif

// ==== pkg/slave_address_composer_pkg.sv ====
// Purpose: types of the slave address composer
// Assumes: defines header on the include path
// Notes:   none
`include "slave_address_composer_defines.svh"
package slave_address_composer_pkg;
   typedef logic [`SAC_ADDR_WIDTH-1:0] addr_t;
   typedef logic [`SAC_HW_WIDTH-1:0]   hw_t;
   typedef struct packed
   {
      logic  valid;
      addr_t addr;
   } frame_addr_s;
   typedef enum logic [2:0]
   {
      ST_CAPTURE = 3'b001,
      ST_RUN     = 3'b010,
      ST_FAULT   = 3'b100
   } comp_state_e;
endpackage

// ==== sim/slave_address_composer_assertions.sv ====
// Purpose: concurrent checks on the composer's ports
// Assumes: bound into the composer's top module
// Notes:   all checks rest while the power-on reset is low
`timescale 1ns/1ps
`default_nettype none
module sac_chk
   import slave_address_composer_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [4:0]  dipSwitch,
   input wire addr_t       storedOffset,
   input wire frame_addr_s frameAddr,
   input wire logic        frameMatch,
   input wire addr_t       slaveAddr,
   input wire logic        addrValid,
   input wire logic        addrFault
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   wire hit = addrValid && frameAddr.valid && (frameAddr.addr == slaveAddr);

   sequence cap;
      $rose(addrValid);
   endsequence

   a_match_ok: assert property (hit |=> frameMatch)
      else $error("matching frame not answered");
   a_match_no: assert property (!hit |=> !frameMatch)
      else $error("frame answered without a match");
   a_cap_first: assert property (!addrValid |=> addrValid)
      else $error("address not captured after reset");
   a_addr_hold: assert property (addrValid |=> $stable(slaveAddr))
      else $error("address moved after capture");
   a_addr_range: assert property (addrValid |-> slaveAddr inside {[1:247]})
      else $error("address out of range");
   a_addr_sum: assert property (cap ##0 !addrFault |->
      slaveAddr == $past(dipSwitch) + $past(storedOffset))
      else $error("address is not switch plus offset");
   a_fault_set: assert property (cap |->
      addrFault == !($past(storedOffset) inside {[1:216]}))
      else $error("fault flag wrong for the offset");
   a_fault_use: assert property (cap ##0 addrFault |->
      slaveAddr == $past(dipSwitch) + 1)
      else $error("fallback address wrong");
endmodule
bind slave_address_composer sac_chk sac_chk_i
(
   .clk          (clk),
   .rst_n        (rst_n),
   .dipSwitch    (dipSwitch),
   .storedOffset (storedOffset),
   .frameAddr    (frameAddr),
   .frameMatch   (frameMatch),
   .slaveAddr    (slaveAddr),
   .addrValid    (addrValid),
   .addrFault    (addrFault)
);
`default_nettype wire

// ==== sim/modbus_master_model.sv ====
// Purpose: bus master stand-in that presents frame address fields
// Assumes: go and dst change at the falling edge
// Notes:   one frame per cycle while go is high
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model import slave_address_composer_pkg::*;
(input wire logic go, input wire addr_t dst, output frame_addr_s fa);
   // idle bus shows the inverse so stale addresses never match
   assign fa = go ? {1'b1, dst} : {1'b0, ~dst};
endmodule
`default_nettype wire

// ==== sim/slave_address_composer_tb_top.sv ====
// Purpose: regression of the slave address composer
// Assumes: fixed seed, stimulus at the falling edge
// Notes:   each rst_n pulse stands for a power-up
`timescale 1ns/1ps
`default_nettype none
module slave_address_composer_tb_top;
import slave_address_composer_pkg::*;
logic clk = 0, rst_n = 0, go = 0, fm, av, af;
logic [4:0] dip = 0;
addr_t off = 8'h01, dst = 8'h00, sa;
frame_addr_s fa;
int mismatches = 0, cmpCount = 0;
always #25 clk = ~clk;
slave_address_composer slave_address_composer_i (.clk(clk), .rst_n(rst_n),
   .dipSwitch(dip), .storedOffset(off), .frameAddr(fa), .frameMatch(fm),
   .slaveAddr(sa), .addrValid(av), .addrFault(af));
modbus_master_model modbus_master_model_i (.go(go), .dst(dst), .fa(fa));
function automatic logic [9:0] want(logic [4:0] d, addr_t o);
   logic bad = !(o inside {[1:216]});
   return {1'b1, bad, 8'({3'h0, d} + (bad ? 8'h01 : o))};
endfunction
task chk(input logic [9:0] seen, input logic [9:0] exp);
   cmpCount++;
   if (seen !== exp)
   begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
   end
endtask
task boot(input logic [4:0] d, input addr_t o, input int n);
   addr_t a;
   logic [9:0] w;
   w = want(d, o);
   rst_n = 0;
   dip = d;
   off = o;
   repeat (n) @(negedge clk);
   chk({av, af, sa}, 10'h001);
   rst_n = 1;
   @(negedge clk);
   chk({av, af, sa}, w);
   dip = ~d;
   off = o + 8'h07;
   go = 1;
   repeat (6)
   begin
      a = ($urandom % 2) ? w[7:0] : 8'($urandom);
      dst = a;
      @(negedge clk);
      chk(fm, a == w[7:0]);
   end
   go = 0;
   @(negedge clk);
   chk(fm, 1'b0);
   chk({av, af, sa}, w);
endtask
task test_done;
   $display("mismatches %0d cmpCount %0d", mismatches, cmpCount);
   if (mismatches == 0 && cmpCount > 0)
      $display("Regression OK");
   else
      $display("Regression broken");
   $finish;
endtask
initial
begin
   void'($urandom(32'h2bbb));
   boot(5'h00, 8'h01, 20);
   boot(5'h05, 8'h71, 2);
   boot(5'h1f, 8'hd8, 2);
   boot(5'h08, 8'h00, 2);
   boot(5'h01, 8'hd9, 2);
   repeat (8) boot(5'($urandom), 8'(1 + $urandom % 216), 2);
   test_done;
end
initial
begin
   #100us;
   mismatches++;
   test_done;
end
endmodule
`default_nettype wire
